// File: rtl/usi_pkg.sv
package usi_pkg;

  // ------------------------------------------------------------------
  // Register map (printed offsets are word indices: byte addr = 4*index)
  // ------------------------------------------------------------------
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_OTP_ONE_CFG = 10'h01f;
  localparam logic [IDX_W-1:0] IDX_OTP_TWO_CFG = 10'h020;
  localparam logic [IDX_W-1:0] IDX_SILICON_REV = 10'h260;
  localparam logic [IDX_W-1:0] IDX_LINK_CTRL = 10'h262;

  // ------------------------------------------------------------------
  // Field positions of link_indicator_control
  // ------------------------------------------------------------------
  localparam int B_LEVEL_BIT = 13;
  localparam int B_COND_LSB = 10;
  localparam int B_DRIVE_LSB = 8;
  localparam int A_LEVEL_BIT = 5;
  localparam int A_COND_LSB = 2;
  localparam int A_DRIVE_LSB = 0;

  // Field positions inside one configuration store byte
  localparam int OTP_COND_LSB = 2;
  localparam int OTP_DRIVE_LSB = 0;
  localparam int OTP_BYTE_W = 8;

  // ------------------------------------------------------------------
  // Codes and reset values
  // ------------------------------------------------------------------
  localparam logic [2:0] COND_SUSP_OR_RST = 3'h0;
  localparam logic [2:0] COND_SUSP = 3'h1;
  localparam logic [2:0] COND_SUSP_LOWPWR = 3'h2;
  localparam logic [1:0] DRIVE_OPEN = 2'h1;
  localparam logic [1:0] DRIVE_PUSH = 2'h2;
  localparam logic [2:0] COND_RST = 3'h0;
  localparam logic [1:0] DRIVE_RST = 2'h2;
  localparam logic [7:0] OTP_BYTE_RST = 8'h00;
  localparam logic [15:0] REVISION_DEFAULT = 16'h0000;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] cond;
    logic [1:0] drive;
  } usi_pin_cfg_t;

  typedef struct packed {
    logic suspended;
    logic bus_reset;
    logic low_power;
  } usi_link_t;

  // Power-up load sequence
  typedef enum logic [1:0] {
    LD_WAIT = 2'b00,
    LD_LOAD = 2'b01,
    LD_RUN = 2'b11
  } usi_load_state_t;

endpackage

// File: rtl/usi_pin_drive.sv
module usi_pin_drive
  import usi_pkg::*;
#(
  parameter bit ACTIVE_LOW_COMBINED = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire usi_pin_cfg_t cfg_i,
  input wire usi_link_t link_i,
  output logic pin_o,
  output logic pin_oe_n_o
);

  // ------------------------------------------------------------------
  // Condition decode
  // ------------------------------------------------------------------
  wire logic cond_combined = link_i.suspended | link_i.bus_reset;
  wire logic cond_lowpwr = link_i.suspended & link_i.low_power;

  logic asserted;
  always_comb begin
    case (cfg_i.cond)
      COND_SUSP_OR_RST: asserted = cond_combined;
      COND_SUSP: asserted = link_i.suspended;
      // High-power devices are not served by this code
      COND_SUSP_LOWPWR: asserted = cond_lowpwr;
      default: asserted = 1'b0;
    endcase
  end

  // Combined mode on the first pin asserts low, everything else high
  wire logic low_active = ACTIVE_LOW_COMBINED &&
                          (cfg_i.cond == COND_SUSP_OR_RST);
  wire logic level = asserted ^ low_active;

  // ------------------------------------------------------------------
  // Drive type: invalid codes release the pin rather than fight a load
  // ------------------------------------------------------------------
  logic next_pin;
  logic next_oe_n;
  always_comb begin
    case (cfg_i.drive)
      DRIVE_PUSH: begin
        next_pin = level;
        next_oe_n = 1'b0;
      end
      DRIVE_OPEN: begin
        next_pin = 1'b0;
        next_oe_n = level;
      end
      default: begin
        next_pin = 1'b0;
        next_oe_n = 1'b1;
      end
    endcase
  end

  // Registered pad controls
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else begin
      pin_o <= next_pin;
      pin_oe_n_o <= next_oe_n;
    end
  end

endmodule

// File: rtl/usi_indicator_pins.sv
module usi_indicator_pins
  import usi_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic [15:0] SILICON_REV = REVISION_DEFAULT  // Arbitrary value
) (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic USB_SUSPENDED_I,
  input wire logic USB_BUS_RESET_I,
  input wire logic USB_LOW_POWER_I,
  input wire logic [7:0] OTP_ONE_CFG_I,
  input wire logic [7:0] OTP_TWO_CFG_I,
  input wire logic OTP_ONE_PROGRAMMED_I,
  input wire logic OTP_TWO_PROGRAMMED_I,
  input wire logic INDICATOR_PIN_A_I,
  output logic INDICATOR_PIN_A_O,
  output logic INDICATOR_PIN_A_OE_N_O,
  input wire logic INDICATOR_PIN_B_I,
  output logic INDICATOR_PIN_B_O,
  output logic INDICATOR_PIN_B_OE_N_O
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  // The highest register index must fit in the word address
  if (ADDR_W < IDX_W + 2 || ADDR_W > 32) begin : g_bad_addr_w
    $error("usi_indicator_pins: ADDR_W must be 12 to 32");
  end

  // The checks below guard package edits; the layout is hard wired
  // Store bytes are one byte wide and their fields must fit one byte
  if (OTP_BYTE_W != 8 || OTP_COND_LSB + 3 > OTP_BYTE_W ||
      OTP_DRIVE_LSB + 2 > OTP_COND_LSB) begin : g_bad_store
    $error("usi_indicator_pins: store byte layout does not fit");
  end

  // The read select is one-hot, so every index must be distinct
  if (IDX_OTP_ONE_CFG == IDX_OTP_TWO_CFG ||
      IDX_OTP_ONE_CFG == IDX_SILICON_REV ||
      IDX_OTP_ONE_CFG == IDX_LINK_CTRL ||
      IDX_OTP_TWO_CFG == IDX_SILICON_REV ||
      IDX_OTP_TWO_CFG == IDX_LINK_CTRL ||
      IDX_SILICON_REV == IDX_LINK_CTRL) begin : g_bad_map
    $error("usi_indicator_pins: two registers share one index");
  end

  // Level bits must stay inside the 16-bit control word
  if (B_LEVEL_BIT > 15 || A_LEVEL_BIT > 15) begin : g_bad_level_pos
    $error("usi_indicator_pins: level bit outside the control word");
  end

  // Pin a fields are written through byte lane 0 only
  if (A_DRIVE_LSB + 2 > A_COND_LSB || A_COND_LSB + 3 > 8 ||
      A_LEVEL_BIT < A_COND_LSB + 3) begin : g_bad_lane_a
    $error("usi_indicator_pins: pin a fields leave byte lane 0");
  end

  // Pin b fields are written through byte lane 1 only
  if (B_DRIVE_LSB < 8 || B_DRIVE_LSB + 2 > B_COND_LSB ||
      B_COND_LSB + 3 > B_LEVEL_BIT) begin : g_bad_lane_b
    $error("usi_indicator_pins: pin b fields leave byte lane 1");
  end

  // The condition decode needs three distinct codes
  if (COND_SUSP_OR_RST == COND_SUSP || COND_SUSP == COND_SUSP_LOWPWR ||
      COND_SUSP_OR_RST == COND_SUSP_LOWPWR) begin : g_bad_cond
    $error("usi_indicator_pins: condition codes are not distinct");
  end

  // A reserved reset condition would hold both pins deasserted
  if (COND_RST != COND_SUSP_OR_RST && COND_RST != COND_SUSP &&
      COND_RST != COND_SUSP_LOWPWR) begin : g_bad_cond_rst
    $error("usi_indicator_pins: reset condition code is reserved");
  end

  // A reset drive code of 00 or 11 would power up with the pad released
  if (DRIVE_RST != DRIVE_PUSH && DRIVE_RST != DRIVE_OPEN) begin : g_bad_drv
    $error("usi_indicator_pins: reset drive code is invalid");
  end

  // ------------------------------------------------------------------
  // Power-up load sequencer
  // ------------------------------------------------------------------
  usi_load_state_t ld_state;
  usi_load_state_t next_ld_state;

  // Straps are sampled by a clocked step after release, never in reset
  always_comb begin
    case (ld_state)
      LD_WAIT: next_ld_state = LD_LOAD;
      LD_LOAD: next_ld_state = LD_RUN;
      LD_RUN: next_ld_state = LD_RUN;
      default: next_ld_state = LD_WAIT;
    endcase
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ld_state <= LD_WAIT;
    end else begin
      ld_state <= next_ld_state;
    end
  end

  // The store gives no ready signal; its outputs are taken as settled
  // once reset has ended, so the load waits a single step only
  wire logic do_load = (ld_state == LD_LOAD);
  wire logic running = (ld_state == LD_RUN);

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  wire logic [IDX_W-1:0] idx = PADDR_I[IDX_W+1:2];
  wire logic upper_zero = (PADDR_I >> (IDX_W + 2)) == '0;
  wire logic aligned = (PADDR_I[1:0] == 2'b00) && upper_zero;

  wire logic hit_one = aligned && (idx == IDX_OTP_ONE_CFG);
  wire logic hit_two = aligned && (idx == IDX_OTP_TWO_CFG);
  wire logic hit_rev = aligned && (idx == IDX_SILICON_REV);
  wire logic hit_ctrl = aligned && (idx == IDX_LINK_CTRL);
  wire logic hit_any = hit_one | hit_two | hit_rev | hit_ctrl;

  // Setup phase: the answer is prepared one cycle ahead
  wire logic setup = PSEL_I & ~PENABLE_I;
  // Access edge at which a transfer completes
  wire logic access = PSEL_I & PENABLE_I & PREADY_O;
  wire logic wr_access = access & PWRITE_I & ~PSLVERR_O;

  // Writes before the load has settled are dropped so the load wins
  wire logic wr_ok = wr_access & running;
  // Byte lanes 2 and 3 reach no register bits and are ignored
  wire logic wr_lane0 = wr_ok & PSTRB_I[0];
  wire logic wr_lane1 = wr_ok & PSTRB_I[1];

  // ------------------------------------------------------------------
  // Configuration store shadow bytes and live fields
  // ------------------------------------------------------------------
  // Shadow bytes mirror the store; staging a value never reprograms it
  logic [OTP_BYTE_W-1:0] otp_indicator_one_cfg;
  logic [OTP_BYTE_W-1:0] otp_indicator_two_cfg;
  usi_pin_cfg_t pin_a_cfg;
  usi_pin_cfg_t pin_b_cfg;
  usi_pin_cfg_t next_pin_a_cfg;
  usi_pin_cfg_t next_pin_b_cfg;
  logic [OTP_BYTE_W-1:0] next_otp_one;
  logic [OTP_BYTE_W-1:0] next_otp_two;

  // Fields of an unprogrammed store byte do not take effect
  wire usi_pin_cfg_t otp_a_cfg = '{
    cond: OTP_ONE_CFG_I[OTP_COND_LSB +: 3],
    drive: OTP_ONE_CFG_I[OTP_DRIVE_LSB +: 2]
  };
  wire usi_pin_cfg_t otp_b_cfg = '{
    cond: OTP_TWO_CFG_I[OTP_COND_LSB +: 3],
    drive: OTP_TWO_CFG_I[OTP_DRIVE_LSB +: 2]
  };

  // Software write fields of link_indicator_control
  wire usi_pin_cfg_t wr_a_cfg = '{
    cond: PWDATA_I[A_COND_LSB +: 3],
    drive: PWDATA_I[A_DRIVE_LSB +: 2]
  };
  wire usi_pin_cfg_t wr_b_cfg = '{
    cond: PWDATA_I[B_COND_LSB +: 3],
    drive: PWDATA_I[B_DRIVE_LSB +: 2]
  };

  // Next values: the load step, then byte-lane writes
  // A write and the load never meet in one cycle: writes need RUN
  always_comb begin
    next_pin_a_cfg = pin_a_cfg;
    next_pin_b_cfg = pin_b_cfg;
    next_otp_one = otp_indicator_one_cfg;
    next_otp_two = otp_indicator_two_cfg;
    if (do_load) begin
      next_otp_one = OTP_ONE_CFG_I;
      next_otp_two = OTP_TWO_CFG_I;
      if (OTP_ONE_PROGRAMMED_I) begin
        next_pin_a_cfg = otp_a_cfg;
      end
      if (OTP_TWO_PROGRAMMED_I) begin
        next_pin_b_cfg = otp_b_cfg;
      end
    end
    if (wr_lane0 && hit_ctrl) begin
      next_pin_a_cfg = wr_a_cfg;
    end
    if (wr_lane1 && hit_ctrl) begin
      next_pin_b_cfg = wr_b_cfg;
    end
    // Shadow bytes only hold a staged value, nothing is reprogrammed
    if (wr_lane0 && hit_one) begin
      next_otp_one = PWDATA_I[7:0];
    end
    if (wr_lane0 && hit_two) begin
      next_otp_two = PWDATA_I[7:0];
    end
  end

  // Live configuration and shadow bytes
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pin_a_cfg <= '{cond: COND_RST, drive: DRIVE_RST};
      pin_b_cfg <= '{cond: COND_RST, drive: DRIVE_RST};
      otp_indicator_one_cfg <= OTP_BYTE_RST;
      otp_indicator_two_cfg <= OTP_BYTE_RST;
    end else begin
      pin_a_cfg <= next_pin_a_cfg;
      pin_b_cfg <= next_pin_b_cfg;
      otp_indicator_one_cfg <= next_otp_one;
      otp_indicator_two_cfg <= next_otp_two;
    end
  end

  // ------------------------------------------------------------------
  // Pin level readback
  // ------------------------------------------------------------------
  // Pads are synchronous to the core clock, one stage aligns them
  // Readback lags the pad by one cycle; pulses shorter than a clock
  // period may never be seen by software
  logic pin_a_level;
  logic pin_b_level;
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pin_a_level <= 1'b0;
      pin_b_level <= 1'b0;
    end else begin
      pin_a_level <= INDICATOR_PIN_A_I;
      pin_b_level <= INDICATOR_PIN_B_I;
    end
  end

  // ------------------------------------------------------------------
  // Read data assembly
  // ------------------------------------------------------------------
  // Control word layout, bit 15 down to 0:
  //   15:14 reserved, read as zero
  //   13    pin b pad level, read only
  //   12:10 pin b condition
  //   9:8   pin b drive
  //   7:6   reserved, read as zero
  //   5     pin a pad level, read only
  //   4:2   pin a condition
  //   1:0   pin a drive
  // Level bits have no storage, so writes cannot reach them
  logic [15:0] ctrl_word;
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[B_LEVEL_BIT] = pin_b_level;
    ctrl_word[B_COND_LSB +: 3] = pin_b_cfg.cond;
    ctrl_word[B_DRIVE_LSB +: 2] = pin_b_cfg.drive;
    ctrl_word[A_LEVEL_BIT] = pin_a_level;
    ctrl_word[A_COND_LSB +: 3] = pin_a_cfg.cond;
    ctrl_word[A_DRIVE_LSB +: 2] = pin_a_cfg.drive;
  end

  wire logic [31:0] rd_one = {24'h000000, otp_indicator_one_cfg};
  wire logic [31:0] rd_two = {24'h000000, otp_indicator_two_cfg};
  wire logic [31:0] rd_rev = {16'h0000, SILICON_REV};
  wire logic [31:0] rd_ctrl = {16'h0000, ctrl_word};

  // One-hot select; unmapped reads return zero
  wire logic [31:0] rd_mux = ({32{hit_one}} & rd_one) |
                             ({32{hit_two}} & rd_two) |
                             ({32{hit_rev}} & rd_rev) |
                             ({32{hit_ctrl}} & rd_ctrl);

  // ------------------------------------------------------------------
  // APB answer flops
  // ------------------------------------------------------------------
  // Ready rises for exactly the first access cycle of each transfer
  // No wait states: a refused transfer is answered in the same cycle,
  // only with the error flag set, so masters need no special case
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
    end else begin
      PREADY_O <= setup;
      PSLVERR_O <= setup & ~hit_any;
      if (setup && !PWRITE_I) begin
        PRDATA_O <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  // Both pins see the same link condition; each has its own configuration, and the polarity differs in combined mode only
  // Pad controls: OE_N low drives the pin value, OE_N high releases the
  // pad to its board pull-up, so open drain only ever drives low
  wire usi_link_t link = '{
    suspended: USB_SUSPENDED_I,
    bus_reset: USB_BUS_RESET_I,
    low_power: USB_LOW_POWER_I
  };

  // First pin: combined mode is active low
  usi_pin_drive #(
    .ACTIVE_LOW_COMBINED(1'b1)
  ) u_pin_a (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .cfg_i(pin_a_cfg),
    .link_i(link),
    .pin_o(INDICATOR_PIN_A_O),
    .pin_oe_n_o(INDICATOR_PIN_A_OE_N_O)
  );

  // Second pin: every mode is active high
  usi_pin_drive #(
    .ACTIVE_LOW_COMBINED(1'b0)
  ) u_pin_b (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .cfg_i(pin_b_cfg),
    .link_i(link),
    .pin_o(INDICATOR_PIN_B_O),
    .pin_oe_n_o(INDICATOR_PIN_B_OE_N_O)
  );

endmodule

// File: verif/usi_indicator_pins_checker.sv
module usi_indicator_pins_checker
  import usi_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic [15:0] SILICON_REV = REVISION_DEFAULT
) (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic USB_SUSPENDED_I,
  input wire logic USB_BUS_RESET_I,
  input wire logic INDICATOR_PIN_B_I,
  input wire logic INDICATOR_PIN_B_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Bus and pin relations
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_A = ADDR_W'({IDX_LINK_CTRL, 2'b00});
  localparam logic [ADDR_W-1:0] REV_A = ADDR_W'({IDX_SILICON_REV, 2'b00});
  logic [2:0] pb_hist;
  wire link_busy = USB_SUSPENDED_I | USB_BUS_RESET_I;
  // Pad history, so level reads are judged only on a steady pad
  always_ff @(posedge MCLK_I) begin
    pb_hist <= {pb_hist[1:0], INDICATOR_PIN_B_I};
  end
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  sequence setup_s;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence ctrl_read_s;
    PREADY_O && !PWRITE_I && PADDR_I == CTRL_A;
  endsequence
  chk_ready_after_setup: assert property (setup_s |=> PREADY_O)
    else $error("no ready one cycle after setup");
  chk_ready_in_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
    else $error("ready outside an access cycle");
  chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  chk_misaligned_err: assert property (
    setup_s ##0 PADDR_I[1:0] != 2'h0 |=> PSLVERR_O)
    else $error("misaligned access not refused");
  chk_err_reads_zero: assert property (
    PREADY_O && PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0)
    else $error("refused read returned data");
  chk_rev_value: assert property (PREADY_O && !PWRITE_I && PADDR_I == REV_A
    |-> PRDATA_O == {16'h0, SILICON_REV})
    else $error("revision read wrong");
  chk_ctrl_reserved: assert property (ctrl_read_s
    |-> PRDATA_O[31:14] == 18'h0 && PRDATA_O[7:6] == 2'h0)
    else $error("reserved control bits not zero");
  chk_level_b: assert property (
    ctrl_read_s ##0 pb_hist == {3{INDICATOR_PIN_B_I}}
    |-> PRDATA_O[13] == INDICATOR_PIN_B_I)
    else $error("pin b level bit wrong");
  chk_idle_b_low: assert property (
    !link_busy [*3] |-> !INDICATOR_PIN_B_O)
    else $error("pin b asserted on idle link");
endmodule

bind usi_indicator_pins usi_indicator_pins_checker #(
  .ADDR_W(ADDR_W),
  .SILICON_REV(SILICON_REV)
) chk_i (
  .MCLK_I, .SYS_RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
  .PRDATA_O, .PREADY_O, .PSLVERR_O, .USB_SUSPENDED_I, .USB_BUS_RESET_I,
  .INDICATOR_PIN_B_I, .INDICATOR_PIN_B_O
);

// File: verif/usi_board.sv
module usi_board (
  input wire logic pin_i,
  input wire logic oe_n_i,
  output logic pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board pull-up: a released pin reads high, never a stale value
  assign pad_o = oe_n_i ? 1'b1 : pin_i;
endmodule

// File: verif/tb_usi_indicator_pins.sv
module tb_usi_indicator_pins
  import usi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Stimulus, model and checks
  // ------------------------------------------------------------
  localparam logic [15:0] REV = 16'h5a3c;  // Arbitrary value
  localparam logic [11:0] CTRL_A = {IDX_LINK_CTRL, 2'b00};
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, susp = 1'b0, brst = 1'b0, lowp = 1'b0, prog = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, erv, pad_a, pad_b, a_o, a_oe, b_o, b_oe;
  int fail_count = 0, checks_done = 0, cycles = 0;
  usi_indicator_pins #(.ADDR_W(12), .SILICON_REV(REV)) DUT (
    .MCLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PSTRB_I(4'h3), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .USB_SUSPENDED_I(susp), .USB_BUS_RESET_I(brst),
    .USB_LOW_POWER_I(lowp), .OTP_ONE_CFG_I(8'h05), .OTP_TWO_CFG_I(8'h0a),
    .OTP_ONE_PROGRAMMED_I(prog), .OTP_TWO_PROGRAMMED_I(prog),
    .INDICATOR_PIN_A_I(pad_a), .INDICATOR_PIN_A_O(a_o),
    .INDICATOR_PIN_A_OE_N_O(a_oe), .INDICATOR_PIN_B_I(pad_b),
    .INDICATOR_PIN_B_O(b_o), .INDICATOR_PIN_B_OE_N_O(b_oe));
  usi_board brd_a (.pin_i(a_o), .oe_n_i(a_oe), .pad_o(pad_a));
  usi_board brd_b (.pin_i(b_o), .oe_n_i(b_oe), .pad_o(pad_b));
  always #4 clk = ~clk;
  // Hang guard, well above the length of the sequence
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Request held until ready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pads(input logic ea, input logic eb);
    check("pad a", {31'h0, ea}, {31'h0, pad_a});
    check("pad b", {31'h0, eb}, {31'h0, pad_b});
  endtask
  initial begin
    logic [2:0] c;
    logic s, r, l, la, lb;
    int k;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, CTRL_A, 32'h0);
    check("ctrl reset", 32'h0222, rdv);
    pads(1'b1, 1'b0);
    apb(1'b0, {IDX_OTP_ONE_CFG, 2'b00}, 32'h0);
    check("store one", 32'h05, rdv);
    apb(1'b1, {IDX_OTP_ONE_CFG, 2'b00}, 32'h01ab);
    apb(1'b0, {IDX_OTP_ONE_CFG, 2'b00}, 32'h0);
    check("store one wr", 32'hab, rdv);
    // Every condition code against idle, suspend, low power, bus reset
    for (int i = 0; i < 32; i++) begin
      c = 3'(i / 4);
      k = i % 4;
      s = k == 1 || k == 2;
      r = k == 3;
      l = k == 2;
      apb(1'b1, CTRL_A, {16'h0, 3'b111, c, 2'h2, 3'b111, c, 2'h2});
      susp <= s;
      brst <= r;
      lowp <= l;
      repeat (4) @(posedge clk);
      lb = c == 3'h0 ? s | r : c == 3'h1 ? s : c == 3'h2 ? s & l : 1'b0;
      la = c == 3'h0 ? ~(s | r) : lb;
      pads(la, lb);
      apb(1'b0, CTRL_A, 32'h0);
      check("ctrl", {18'h0, lb, c, 4'h8, la, c, 2'h2}, rdv);
    end
    susp <= 1'b0;
    brst <= 1'b0;
    // Drive codes with the pin deasserted: invalid ones release it
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, CTRL_A, {16'h0, 6'h01, 2'(d), 6'h01, 2'(d)});
      repeat (3) @(posedge clk);
      check("oe a", {31'h0, d == 0 || d == 3}, {31'h0, a_oe});
      check("oe b", {31'h0, d == 0 || d == 3}, {31'h0, b_oe});
      check("out b", 32'h0, {31'h0, b_o});
    end
    apb(1'b1, CTRL_A, 32'h0505);
    susp <= 1'b1;
    repeat (4) @(posedge clk);
    check("oe b open", 32'h1, {31'h0, b_oe});
    check("out a open", 32'h0, {31'h0, a_o});
    pads(1'b1, 1'b1);
    susp <= 1'b0;
    apb(1'b1, {IDX_SILICON_REV, 2'b00}, 32'hffff);
    apb(1'b0, {IDX_SILICON_REV, 2'b00}, 32'h0);
    check("revision", {16'h0, REV}, rdv);
    apb(1'b0, 12'h990, 32'h0);
    check("unmapped err", 32'h1, {31'h0, erv});
    check("unmapped data", 32'h0, rdv);
    apb(1'b1, CTRL_A | 12'h1, 32'h0);
    check("misaligned err", 32'h1, {31'h0, erv});
    // Programmed store bytes must win over the reset defaults
    prog <= 1'b1;
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, CTRL_A, 32'h0);
    check("ctrl loaded", 32'h0a05, rdv);
    report_and_stop();
  end
endmodule
